/* src/stepper_i2c_regs.svh */
// register offsets, field positions, reset values and address constants of the serial front end
`ifndef STEPPER_I2C_REGS_SVH
`define STEPPER_I2C_REGS_SVH

`define OPERATING_CONFIG_OFFSET           6'h00
`define WATCHDOG_INTERVAL_OFFSET          6'h01
`define WATCHDOG_CONTROL_OFFSET           6'h02
`define GPIO_DIRECTION_CONFIG_OFFSET      6'h03
`define IRQ_EDGE_MODE_OFFSET              6'h04
`define IRQ_MASK_OFFSET                   6'h05
`define IRQ_STATUS_OFFSET                 6'h06
`define GPIO_INPUT_LEVEL_OFFSET           6'h07
`define IRQ_MOTOR_RESPONSE_OFFSET         6'h08
`define SENSOR0_EXTRA_STEP_COUNT_OFFSET   6'h09
`define SENSOR1_EXTRA_STEP_COUNT_OFFSET   6'h0a
`define DRIVE_OUTPUT_PHASE_CONFIG_OFFSET  6'h0b
`define DRIVE_OUTPUT_STATE_TIMEOUT_OFFSET 6'h0c
`define ACCEL_RAMP_CONTROL_OFFSET         6'h0d
`define DECEL_RAMP_CONTROL_OFFSET         6'h0e
`define STEP_COUNT_FIRST_OFFSET           6'h1f
`define LAST_REG_OFFSET                   6'h22
`define REG_COUNT                         35

`define REGISTER_POINTER_RESET            8'h80
`define AUTOSTEP_BIT                      7
`define POINTER_WIDTH                     6

`define SLAVE_ADDR_FAMILY                 3'h2
`define BITS_PER_BYTE                     4'h8

`endif

/* src/stepper_i2c_pkg.sv */
// types used by the serial front end; its register bank uses none of them
package stepper_i2c_pkg;

  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_ADDR      = 10'h002,
    ST_ADDR_ACK  = 10'h004,
    ST_CMD       = 10'h008,
    ST_CMD_ACK   = 10'h010,
    ST_WDATA     = 10'h020,
    ST_WDATA_ACK = 10'h040,
    ST_RDATA     = 10'h080,
    ST_RDATA_ACK = 10'h100,
    ST_HALT      = 10'h200
  } link_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } bus_event_t;

  typedef struct packed {
    logic seen_low;
    logic seen_high;
    logic differs_scl;
  } strap_watch_t;

  typedef struct packed {
    logic       autostep;
    logic       spare;
    logic [5:0] pointer;
  } command_t;

endpackage

/* src/reg_bank.sv */
// register bank behind the serial pointer, registered read port
`timescale 1ns/1ps
module reg_bank #(
  parameter int DEPTH = 35,
  parameter int WIDTH = 8,
  parameter int AW    = 6
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  input  wire logic             i_write,
  input  wire logic [AW-1:0]    i_write_addr,
  input  wire logic [WIDTH-1:0] i_write_data,
  input  wire logic [AW-1:0]    i_read_addr,
  output logic      [WIDTH-1:0] o_read_data
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] read_next;

  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    logic [WIDTH-1:0] entry_next;
    assign entry_next = (i_write && (i_write_addr == AW'(e))) ? i_write_data : mem_reg[e];
    always_ff @(posedge i_clock) begin
      if (i_reset) begin
        mem_reg[e] <= '0;
      end else begin
        mem_reg[e] <= entry_next;
      end
    end
  end

  always_comb begin
    read_next = '0;
    if (32'(i_read_addr) < DEPTH) begin
      read_next = mem_reg[i_read_addr];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_read_data <= '0;
    end else begin
      o_read_data <= read_next;
    end
  end

endmodule // reg_bank

/* src/i2c_slave_register_access.sv */
// serial slave front end: strap address decode, command pointer, register bank access
`timescale 1ns/1ps
`include "stepper_i2c_regs.svh"
module i2c_slave_register_access
  import stepper_i2c_pkg::*;
#(
  parameter int REG_COUNT = `REG_COUNT
) (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe_n,
  input  wire logic       i_address_strap_low,
  input  wire logic       i_address_strap_high,
  output logic [7:0]      o_register_pointer,
  output logic [6:0]      o_slave_address
);

  // ---------------- pin synchronisers ----------------
  // bit 0 scl, bit 1 sda, bit 2 low strap, bit 3 high strap
  logic [3:0] sync1_reg;
  logic [3:0] sync1_next;
  logic [3:0] sync2_reg;
  logic [3:0] sync2_next;
  logic [1:0] prev_reg;
  logic [1:0] prev_next;

  always_comb begin
    sync1_next = {i_address_strap_high, i_address_strap_low, i_sda, i_scl};
    sync2_next = sync1_reg;
    prev_next  = sync2_reg[1:0];
  end

  // no reset on the two stages: they must carry true pin levels when reset lifts,
  // else a grounded strap would look toggled and be taken for a bus line.
  // limitation: reset has to stand for at least two clocks to fill them
  always_ff @(posedge i_clock) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
    if (i_reset) begin
      prev_reg <= 2'h3;
    end else begin
      prev_reg <= prev_next;
    end
  end

  bus_event_t ev;

  always_comb begin
    ev.scl      = sync2_reg[0];
    ev.sda      = sync2_reg[1];
    ev.scl_rise = sync2_reg[0] & ~prev_reg[0];
    ev.scl_fall = ~sync2_reg[0] & prev_reg[0];
    ev.start    = sync2_reg[0] & prev_reg[0] & ~sync2_reg[1] & prev_reg[1];
    ev.stop     = sync2_reg[0] & prev_reg[0] & sync2_reg[1] & ~prev_reg[1];
  end

  // ---------------- strap classification ----------------
  // a strap that has toggled is on a bus line; if it ever disagreed with scl it must be sda.
  // before the first start an scl strap looks like a supply strap, which is harmless
  // because the address is only compared after eight clocks of a frame.
  strap_watch_t watch_reg  [2];
  strap_watch_t watch_next [2];
  logic [1:0]   strap_code [2];

  for (genvar g = 0; g < 2; g++) begin : g_strap
    logic level;
    assign level = sync2_reg[2+g];
    always_comb begin
      watch_next[g].seen_low    = watch_reg[g].seen_low | ~level;
      watch_next[g].seen_high   = watch_reg[g].seen_high | level;
      watch_next[g].differs_scl = watch_reg[g].differs_scl | (level != ev.scl);
      strap_code[g][1] = watch_reg[g].seen_low & watch_reg[g].seen_high;
      strap_code[g][0] = strap_code[g][1] ? watch_reg[g].differs_scl : watch_reg[g].seen_high;
    end
    always_ff @(posedge i_clock) begin
      if (i_reset) begin
        watch_reg[g] <= '0;
      end else begin
        watch_reg[g] <= watch_next[g];
      end
    end
  end

  logic [3:0] variant;
  logic [6:0] addr_reg;
  logic [6:0] addr_next;

  always_comb begin
    variant[3] = strap_code[1][1];
    variant[2] = strap_code[0][1];
    if (strap_code[1][1] && !strap_code[0][1]) begin
      variant[1:0] = {strap_code[0][0], strap_code[1][0]};
    end else begin
      variant[1:0] = {strap_code[1][0], strap_code[0][0]};
    end
    addr_next = {`SLAVE_ADDR_FAMILY, variant};
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      addr_reg <= {`SLAVE_ADDR_FAMILY, 4'h0};
    end else begin
      addr_reg <= addr_next;
    end
  end

  // ---------------- pointer helpers ----------------
  function automatic logic pointer_defined(input logic [5:0] p);
    return p <= `LAST_REG_OFFSET;
  endfunction

  function automatic logic pointer_writable(input logic [5:0] p);
    return pointer_defined(p) && (p != `IRQ_STATUS_OFFSET) && (p != `GPIO_INPUT_LEVEL_OFFSET)
           && (p < `STEP_COUNT_FIRST_OFFSET);
  endfunction

  function automatic logic [5:0] step_pointer(input command_t c);
    if (!c.autostep) begin
      return c.pointer;
    end else if (c.pointer == `LAST_REG_OFFSET) begin
      return 6'h00;
    end else begin
      return c.pointer + 6'h01;
    end
  endfunction

  // ---------------- link state machine ----------------
  link_state_t state_reg;
  link_state_t state_next;
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  command_t    cmd_reg;
  command_t    cmd_next;
  logic        read_dir_reg;
  logic        read_dir_next;
  logic        ack_seen_reg;
  logic        ack_seen_next;
  logic        oe_n_reg;
  logic        oe_n_next;
  logic        bank_write;
  logic [7:0]  read_data;

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    cmd_next      = cmd_reg;
    read_dir_next = read_dir_reg;
    ack_seen_next = ack_seen_reg;
    oe_n_next     = oe_n_reg;
    bank_write    = 1'b0;
    if (ev.stop) begin
      state_next = ST_IDLE;
      oe_n_next  = 1'b1;
    end else if (ev.start) begin
      // a repeated start re-enters address phase from any state
      state_next = ST_ADDR;
      cnt_next   = 4'h0;
      oe_n_next  = 1'b1;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_HALT: begin
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (ev.scl_rise && (cnt_reg < `BITS_PER_BYTE)) begin
            shift_next = {shift_reg[6:0], ev.sda};
            cnt_next   = cnt_reg + 4'h1;
          end else if (ev.scl_fall && (cnt_reg == `BITS_PER_BYTE)) begin
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == addr_reg) begin
                read_dir_next = shift_reg[0];
                state_next    = ST_ADDR_ACK;
                oe_n_next     = 1'b0;
              end else begin
                state_next = ST_HALT;
              end
            end else if (state_reg == ST_CMD) begin
              if (pointer_defined(shift_reg[5:0])) begin
                cmd_next   = shift_reg;
                state_next = ST_CMD_ACK;
                oe_n_next  = 1'b0;
              end else begin
                state_next = ST_HALT;
              end
            end else begin
              // read-only offsets take the byte and acknowledge but keep their value
              bank_write       = pointer_writable(cmd_reg.pointer);
              cmd_next.pointer = step_pointer(cmd_reg);
              state_next       = ST_WDATA_ACK;
              oe_n_next        = 1'b0;
            end
          end
        end
        ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK: begin
          if (ev.scl_fall) begin
            cnt_next = 4'h0;
            if ((state_reg == ST_ADDR_ACK) && read_dir_reg) begin
              state_next = ST_RDATA;
              shift_next = read_data;
              oe_n_next  = read_data[7];
            end else begin
              state_next = (state_reg == ST_ADDR_ACK) ? ST_CMD : ST_WDATA;
              oe_n_next  = 1'b1;
            end
          end
        end
        ST_RDATA: begin
          if (ev.scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (ev.scl_fall) begin
            if (cnt_reg == `BITS_PER_BYTE) begin
              cmd_next.pointer = step_pointer(cmd_reg);
              state_next       = ST_RDATA_ACK;
              oe_n_next        = 1'b1;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_n_next  = shift_reg[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (ev.scl_rise) begin
            ack_seen_next = ~ev.sda;
          end else if (ev.scl_fall) begin
            cnt_next = 4'h0;
            if (ack_seen_reg) begin
              // the bank has re-read the stepped pointer long before this edge
              state_next = ST_RDATA;
              shift_next = read_data;
              oe_n_next  = read_data[7];
            end else begin
              state_next = ST_HALT;
              oe_n_next  = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= 4'h0;
      shift_reg    <= 8'h00;
      cmd_reg      <= `REGISTER_POINTER_RESET;
      read_dir_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      oe_n_reg     <= 1'b1;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      shift_reg    <= shift_next;
      cmd_reg      <= cmd_next;
      read_dir_reg <= read_dir_next;
      ack_seen_reg <= ack_seen_next;
      oe_n_reg     <= oe_n_next;
    end
  end

  reg_bank #(
    .DEPTH (REG_COUNT),
    .WIDTH (8),
    .AW    (`POINTER_WIDTH)
  ) u_bank (
    .i_clock      (i_clock),
    .i_reset      (i_reset),
    .i_write      (bank_write),
    .i_write_addr (cmd_reg.pointer),
    .i_write_data (shift_reg),
    .i_read_addr  (cmd_reg.pointer),
    .o_read_data  (read_data)
  );

  // open drain: the pad only ever pulls low
  assign o_sda              = 1'b0;
  assign o_sda_oe_n         = oe_n_reg;
  assign o_register_pointer = cmd_reg;
  assign o_slave_address    = addr_reg;

endmodule // i2c_slave_register_access

/* bench/i2c_slave_register_access_asserts.sv */
// checker of the serial front end port behaviour
`timescale 1ns/1ps
module i2c_slave_register_access_asserts (
  input wire logic       i_clock,
  input wire logic       i_reset,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda,
  input wire logic       o_sda_oe_n,
  input wire logic       i_address_strap_low,
  input wire logic       i_address_strap_high,
  input wire logic [7:0] o_register_pointer,
  input wire logic [6:0] o_slave_address
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_reset_values: assert property (disable iff (1'b0) i_reset |=>
    o_register_pointer == 8'h80 && o_sda_oe_n && o_slave_address == 7'h20) else $error("reset values wrong");
  a_addr_family: assert property (o_slave_address[6:4] == 3'h2)
    else $error("address family wrong");
  a_ptr_defined: assert property (o_register_pointer[5:0] <= 6'h22)
    else $error("undefined pointer held");
  // 23h may never follow 22h: the step must wrap, not run on
  a_wrap_limit: assert property (o_register_pointer[7] && $past(o_register_pointer[5:0]) == 6'h22
    |-> o_register_pointer[5:0] != 6'h23) else $error("pointer ran past 22h");
  a_ack_holds: assert property ($fell(o_sda_oe_n) |=> !o_sda_oe_n [*3])
    else $error("drive too short");
  a_drive_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl && !$past(i_scl))
    else $error("data driven while clock high");
  a_drive_zero: assert property (!o_sda_oe_n |-> !o_sda)
    else $error("open drain drives high");
  a_hold_ai_off: assert property (!o_register_pointer[7] && !$past(o_register_pointer[7])
    && $changed(o_register_pointer) |-> ##[0:1] !o_sda_oe_n) else $error("pointer moved with autostep clear");

  c_ack: cover property ($fell(o_sda_oe_n));
  c_wrap: cover property ($past(o_register_pointer[5:0]) == 6'h22 && o_register_pointer[5:0] == 6'h00);
  c_step: cover property (o_register_pointer == 8'h86);
endmodule // i2c_slave_register_access_asserts

bind i2c_slave_register_access i2c_slave_register_access_asserts i2c_slave_register_access_asserts_i (
  .i_clock(i_clock), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
  .o_sda_oe_n(o_sda_oe_n), .i_address_strap_low(i_address_strap_low),
  .i_address_strap_high(i_address_strap_high), .o_register_pointer(o_register_pointer),
  .o_slave_address(o_slave_address));

/* bench/i2c_master_model.sv */
// serial bus master model, 320 ns bit period
`timescale 1ns/1ps
module i2c_master_model (
  output logic     o_scl,
  output logic     o_sda_drv,
  input wire logic i_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda_drv = 1'b1;
  end

  // data moves only while the clock is low; clock stands high between frames
  task automatic bit_io(input logic b, output logic r);
    #40 o_sda_drv = b;
    #160 o_scl = 1'b1;
    #60 r = i_sda;
    #60 o_scl = 1'b0;
  endtask

  // long low phase first so a slave still acking has released before the clock rises
  task automatic bus_start;
    o_sda_drv = 1'b1;
    #200 o_scl = 1'b1;
    #80 o_sda_drv = 1'b0;
    #120 o_scl = 1'b0;
  endtask

  task automatic bus_stop;
    #40 o_sda_drv = 1'b0;
    #160 o_scl = 1'b1;
    #80 o_sda_drv = 1'b1;
    #120;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nack);
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // i2c_master_model

/* bench/i2c_slave_register_access_tb.sv */
// self-checking bench of the serial front end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module i2c_slave_register_access_tb;
  logic       i_clock = 1'b0;
  logic       i_reset = 1'b1;
  logic [1:0] lo_sel  = 2'h0;
  logic [1:0] hi_sel  = 2'h0;
  logic       scl, sda_drv, o_sda, oe_n;
  logic [7:0] pointer;
  logic [6:0] slave_addr;
  logic [7:0] d;
  int         failures = 0;
  int         n_checks = 0;
  // wired-and bus with pull-up; straps pick ground, supply, clock or data line
  wire        sda = sda_drv & (oe_n | o_sda);
  wire        strap_lo = lo_sel[1] ? (lo_sel[0] ? sda : scl) : lo_sel[0];
  wire        strap_hi = hi_sel[1] ? (hi_sel[0] ? sda : scl) : hi_sel[0];

  always #20 i_clock = ~i_clock;

  i2c_slave_register_access i2c_slave_register_access_i (
    .i_clock(i_clock), .i_reset(i_reset), .i_scl(scl), .i_sda(sda), .o_sda(o_sda), .o_sda_oe_n(oe_n),
    .i_address_strap_low(strap_lo), .i_address_strap_high(strap_hi),
    .o_register_pointer(pointer), .o_slave_address(slave_addr));
  i2c_master_model i2c_master_model_i (.o_scl(scl), .o_sda_drv(sda_drv), .i_sda(sda));

  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] lo, input logic [1:0] hi);
    @(posedge i_clock) #1 i_reset = 1'b1;
    lo_sel = lo;
    hi_sel = hi;
    repeat (3) @(posedge i_clock);
    #1 i_reset = 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
  endtask

  task automatic send(input logic [7:0] b, input logic nack_exp);
    logic nk;
    i2c_master_model_i.wbyte(b, nk);
    `CHK("ack", nack_exp, nk)
  endtask

  task automatic t_reset_state;
    do_reset(2'h0, 2'h0);
    `CHK("pointer", 8'h80, pointer)
    `CHK("oe_n", 1'b1, oe_n)
    i2c_master_model_i.bus_start();
    send(8'h42, 1'b1);
    i2c_master_model_i.bus_stop();
  endtask

  task automatic t_straps;
    logic [6:0] a;
    for (int k = 0; k < 16; k++) begin
      // a lone bus strap on the high pin takes the second bit, its partner's level the first
      a = (k[3] && !k[1]) ? {3'h2, 2'h2, k[0], k[2]} : {3'h2, k[3], k[1], k[2], k[0]};
      do_reset(k[1:0], k[3:2]);
      i2c_master_model_i.bus_start();
      send({a, 1'b0}, 1'b0);
      i2c_master_model_i.bus_stop();
      `CHK("slave_address", a, slave_addr)
    end
  endtask

  task automatic t_write_read;
    do_reset(2'h0, 2'h0);
    i2c_master_model_i.bus_start();
    send(8'h40, 1'b0);
    send(8'h84, 1'b0);
    `CHK("pointer", 8'h84, pointer)
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    `CHK("pointer", 8'h86, pointer)
    i2c_master_model_i.bus_start();
    send(8'h40, 1'b0);
    send(8'h84, 1'b0);
    i2c_master_model_i.bus_start();
    send(8'h41, 1'b0);
    i2c_master_model_i.rbyte(1'b0, d);
    `CHK("read0", 8'h11, d)
    i2c_master_model_i.rbyte(1'b1, d);
    `CHK("read1", 8'h22, d)
    i2c_master_model_i.bus_stop();
    `CHK("pointer", 8'h86, pointer)
  endtask

  task automatic t_wrap;
    i2c_master_model_i.bus_start();
    send(8'h40, 1'b0);
    send(8'ha2, 1'b0);
    send(8'h5a, 1'b0);
    `CHK("pointer", 8'h80, pointer)
    i2c_master_model_i.bus_start();
    send(8'h40, 1'b0);
    send(8'h23, 1'b1);
    i2c_master_model_i.bus_stop();
    `CHK("pointer", 8'h80, pointer)
  endtask

  task automatic t_hold;
    i2c_master_model_i.bus_start();
    send(8'h40, 1'b0);
    send(8'h04, 1'b0);
    send(8'h33, 1'b0);
    send(8'h44, 1'b0);
    `CHK("pointer", 8'h04, pointer)
    i2c_master_model_i.bus_start();
    send(8'h41, 1'b0);
    i2c_master_model_i.rbyte(1'b1, d);
    `CHK("read", 8'h44, d)
    i2c_master_model_i.bus_stop();
    `CHK("pointer", 8'h04, pointer)
    // a second command with autostep clear moves the pointer only through the command byte
    i2c_master_model_i.bus_start();
    send(8'h40, 1'b0);
    send(8'h05, 1'b0);
    i2c_master_model_i.bus_stop();
    `CHK("pointer", 8'h05, pointer)
  endtask

  // whole run is near 137 us; a hang is cut at 1 ms
  initial begin
    #1000000;
    failures++;
    conclude();
  end

  initial begin
    t_reset_state();
    t_straps();
    t_write_read();
    t_wrap();
    t_hold();
    conclude();
  end
endmodule // i2c_slave_register_access_tb
